// File: inc/adsc_pkg.sv
// constants, field layouts and types of the analog-die serial control block
// assumes: one control byte in, one status byte out per slave-select frame
//
// Functional notes
// - one frame moves exactly one byte each way, control in, status out
// - select falling starts frame, drives serial out, freezes status snapshot
// - bits launch after shift clock rising, sampled on shift clock falling
// - frame counts only with exactly eight sampling edges under select low
// - select rising commits control byte; select high floats serial out
// - control byte: slew hi, slew lo, pullup off, switch 3..1, opsel hi, lo
// - control bits clear on reset, opsel goes to run 11; pullup bit only on power-on reset
// - slew code 00 20k, 01 10k, 10 100k download, 11 low-power request
// - pullup bit set removes bus pullup during sleep and stop
// - switch enable bit one turns output on in run, zero off, reset clears
// - opsel 00 sleep, 01 stop, 10 watchdog clear, 11 run
// - sleep or stop needs the command in two transfers
// - status byte: source, bus flag, over, under, hot, switch, wake 2, 1
// - top status bit one when lower bits show interrupt or wake source
// - first status read after reset shows battery fail in bit 4
// - bus flag sets on bus wake or bus fault; fault blocks transmitter
// - reading bus flag while set clears it
// - overvoltage and undervoltage conditions show in their flags
// - regulator overtemperature warning shows in its flag
// - switch overtemp kills all switches; re-enable needs read then write
// - wake bits follow inputs, or show wake cause while top status bit is set
// - watchdog clear only in open window, otherwise system reset
// - bus wake in stop raises interrupt; in sleep resets system
package adsc_pkg;

  localparam logic [3:0] FRAME_EDGES = 4'h8;
  localparam logic [3:0] EDGE_SAT    = 4'hF;
  localparam logic [2:0] TX_NEXT_BIT = 3'h6;
  localparam int         ST_BUS_BIT  = 6;
  localparam int         ST_EVT_BIT  = 7;
  localparam int         ST_HOT_BIT  = 2;

  localparam logic [1:0] SLEW_20K    = 2'h0;
  localparam logic [1:0] SLEW_10K    = 2'h1;
  localparam logic [1:0] SLEW_100K   = 2'h2;
  localparam logic [1:0] SLEW_LOWPWR = 2'h3;

  localparam logic [1:0] OPSEL_SLEEP = 2'h0;
  localparam logic [1:0] OPSEL_STOP  = 2'h1;
  localparam logic [1:0] OPSEL_WDCLR = 2'h2;
  localparam logic [1:0] OPSEL_RUN   = 2'h3;

  localparam logic [1:0] SLEW_RST    = 2'h0;
  localparam logic       PULLUP_RST  = 1'h0;
  localparam logic [2:0] SWITCH_RST  = 3'h0;
  localparam logic [1:0] OPSEL_RST   = OPSEL_RUN;

  typedef struct packed {
    logic [1:0] slew_select;
    logic       bus_pullup_disconnect;
    logic [2:0] switch_enable;
    logic [1:0] opsel;
  } adsc_ctrl_s;

  typedef struct packed {
    logic       irq_source_indicator;
    logic       bus_flag;
    logic       overvoltage_flag;
    logic       undervoltage_flag;
    logic       regulator_hot_warning;
    logic       switch_overtemp_flag;
    logic       wake_input_two;
    logic       wake_input_one;
  } adsc_status_s;

  typedef struct packed {
    logic bus_wake;
    logic bus_fault;
    logic overvoltage;
    logic undervoltage;
    logic battery_fail;
    logic regulator_hot;
    logic switch_overtemp;
    logic wake_input_two;
    logic wake_input_one;
  } adsc_sense_s;

  typedef enum logic [1:0] {
    ADSC_RUN,
    ADSC_STOP,
    ADSC_SLEEP
  } adsc_power_e;

endpackage

// File: src/adsc_core.sv
// analog-die serial control/status slave with its flag and mode logic
// assumes: shift clock idles low, first rising edge comes 40 ns or more
// after select falls, sense inputs are asynchronous levels
`timescale 1ns/10ps
module adsc_core (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 sys_rst_pin,
  input  wire logic                 shift_clock_pin,
  input  wire logic                 slave_select_n,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      miso_oe_n,
  input  wire adsc_pkg::adsc_sense_s sense,
  output logic [1:0]                slew_select,
  output logic                      bus_pullup_off,
  output logic [2:0]                switch_on,
  output logic                      bus_tx_enable,
  output adsc_pkg::adsc_power_e     power_state,
  output logic                      wdog_clear,
  output logic                      wake_irq,
  output logic                      sys_reset_req
);

  // link side, clocked by select edges and the shift clock
  logic       start_tog;
  logic       rx_seen;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sr;
  logic       tx_seen;
  logic [2:0] tx_bit;
  logic       miso_q;

  // reference side
  logic                   ss_s1, ss_s2, ss_d;
  logic                   srst_s1, srst_s2;
  adsc_pkg::adsc_sense_s  sn_s1, sn_s2, sn_d;
  logic [7:0]             snap;
  adsc_pkg::adsc_ctrl_s   ctrl;
  adsc_pkg::adsc_ctrl_s   ctrl_rx;
  adsc_pkg::adsc_status_s status_now;
  adsc_pkg::adsc_power_e  state;
  logic                   frame_end, frame_ok, is_lp, lp_go;
  logic                   lp_pend, lp_mode;
  logic                   bus_flag, switch_overtemp_flag_flag, evt_pend, first_read;
  logic [1:0]             wake_src;
  logic                   wake_one_rise, wake_two_rise, bus_wake_rise;
  logic                   any_wake, bus_set, hs_block, evt_set;

  // start toggle: flips once per frame so the shift-clock logic can spot
  // the first edge of a frame without an asynchronous clear of its data
  always_ff @(negedge slave_select_n or posedge rst)
  begin
    if (rst)
      start_tog <= 1'b0;
    else
      start_tog <= ~start_tog;
  end

  always_ff @(negedge shift_clock_pin or posedge rst)
  begin
    if (rst)
    begin
      rx_seen <= 1'b0;
      rx_cnt  <= 4'h0;
      rx_sr   <= 8'h00;
    end
    else
    begin
      rx_seen <= start_tog;
      rx_sr   <= {rx_sr[6:0], mosi};
      if (rx_seen != start_tog)
        rx_cnt <= 4'h1;
      else if (rx_cnt != adsc_pkg::EDGE_SAT)
        rx_cnt <= rx_cnt + 4'h1;
    end
  end

  // snapshot is frozen from select low onward, so reading it here is safe
  always_ff @(posedge shift_clock_pin or posedge rst)
  begin
    if (rst)
    begin
      tx_seen <= 1'b0;
      tx_bit  <= 3'h7;
      miso_q  <= 1'b0;
    end
    else if (tx_seen != start_tog)
    begin
      tx_seen <= start_tog;
      miso_q  <= snap[7];
      tx_bit  <= adsc_pkg::TX_NEXT_BIT;
    end
    else
    begin
      miso_q <= snap[tx_bit];
      tx_bit <= tx_bit - 3'h1;
    end
  end

  assign miso      = miso_q;
  assign miso_oe_n = slave_select_n;

  // synchronisers for select, system reset and sense levels
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
      ss_d    <= 1'b1;
      srst_s1 <= 1'b0;
      srst_s2 <= 1'b0;
      sn_s1   <= '0;
      sn_s2   <= '0;
      sn_d    <= '0;
    end
    else
    begin
      ss_s1   <= slave_select_n;
      ss_s2   <= ss_s1;
      ss_d    <= ss_s2;
      srst_s1 <= sys_rst_pin;
      srst_s2 <= srst_s1;
      sn_s1   <= sense;
      sn_s2   <= sn_s1;
      sn_d    <= sn_s2;
    end
  end

  // link registers are quiet once select is high (the shift clock stops),
  // so they are read here without a further synchroniser
  assign ctrl_rx   = adsc_pkg::adsc_ctrl_s'(rx_sr);
  assign frame_end = ss_s2 & ~ss_d;
  assign frame_ok  = frame_end & (rx_seen == start_tog)
                   & (rx_cnt == adsc_pkg::FRAME_EDGES);

  assign is_lp = (ctrl_rx.slew_select == adsc_pkg::SLEW_LOWPWR)
               & (ctrl_rx.switch_enable == 3'h0)
               & ~ctrl_rx.opsel[1];
  assign lp_go = frame_ok & is_lp & lp_pend
               & (lp_mode == ctrl_rx.opsel[0]);

  assign wake_one_rise = sn_s2.wake_input_one & ~sn_d.wake_input_one;
  assign wake_two_rise = sn_s2.wake_input_two & ~sn_d.wake_input_two;
  assign bus_wake_rise = sn_s2.bus_wake & ~sn_d.bus_wake;
  assign any_wake = (state != adsc_pkg::ADSC_RUN)
                  & (wake_one_rise | wake_two_rise | bus_wake_rise);
  assign bus_set  = sn_s2.bus_fault
                  | ((state != adsc_pkg::ADSC_RUN) & bus_wake_rise);
  assign hs_block = switch_overtemp_flag_flag | sn_s2.switch_overtemp;
  assign evt_set  = any_wake | bus_set | sn_s2.switch_overtemp;

  // pending low-power command; invalid frames leave it untouched
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lp_pend <= 1'b0;
      lp_mode <= 1'b0;
    end
    else if (srst_s2 || lp_go)
      lp_pend <= 1'b0;
    else if (frame_ok)
    begin
      lp_pend <= is_lp;
      lp_mode <= ctrl_rx.opsel[0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl.slew_select           <= adsc_pkg::SLEW_RST;
      ctrl.bus_pullup_disconnect <= adsc_pkg::PULLUP_RST;
      ctrl.switch_enable         <= adsc_pkg::SWITCH_RST;
      ctrl.opsel                 <= adsc_pkg::OPSEL_RST;
    end
    else if (srst_s2)
    begin
      ctrl.slew_select   <= adsc_pkg::SLEW_RST;
      ctrl.switch_enable <= adsc_pkg::SWITCH_RST;
      ctrl.opsel         <= adsc_pkg::OPSEL_RST;
    end
    else
    begin
      if (frame_ok)
        ctrl <= ctrl_rx;
      if (hs_block)
        ctrl.switch_enable <= adsc_pkg::SWITCH_RST;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state         <= adsc_pkg::ADSC_RUN;
      sys_reset_req <= 1'b0;
      wake_irq      <= 1'b0;
    end
    else
    begin
      sys_reset_req <= 1'b0;
      wake_irq      <= 1'b0;
      case (state)
        adsc_pkg::ADSC_RUN:
        begin
          if (lp_go && !srst_s2)
            state <= ctrl_rx.opsel[0] ? adsc_pkg::ADSC_STOP
                                      : adsc_pkg::ADSC_SLEEP;
        end
        adsc_pkg::ADSC_STOP:
        begin
          if (any_wake)
          begin
            state    <= adsc_pkg::ADSC_RUN;
            wake_irq <= 1'b1;
          end
        end
        adsc_pkg::ADSC_SLEEP:
        begin
          if (any_wake)
          begin
            state         <= adsc_pkg::ADSC_RUN;
            sys_reset_req <= 1'b1;
          end
        end
        default:
          state <= adsc_pkg::ADSC_RUN;
      endcase
      if (srst_s2)
        state <= adsc_pkg::ADSC_RUN;
    end
  end

  // sticky flags: a set in the same cycle as a read-clear wins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_flag  <= 1'b0;
      switch_overtemp_flag_flag <= 1'b0;
      evt_pend  <= 1'b0;
      wake_src  <= 2'h0;
    end
    else
    begin
      if (bus_set)
        bus_flag <= 1'b1;
      else if (frame_ok && snap[adsc_pkg::ST_BUS_BIT])
        bus_flag <= 1'b0;
      if (sn_s2.switch_overtemp)
        switch_overtemp_flag_flag <= 1'b1;
      else if (frame_ok && snap[adsc_pkg::ST_HOT_BIT])
        switch_overtemp_flag_flag <= 1'b0;
      if (evt_set)
        evt_pend <= 1'b1;
      else if (frame_ok && snap[adsc_pkg::ST_EVT_BIT])
        evt_pend <= 1'b0;
      if (any_wake)
        wake_src <= {wake_two_rise, wake_one_rise};
      else if (frame_ok && snap[adsc_pkg::ST_EVT_BIT])
        wake_src <= 2'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      first_read <= 1'b1;
    else if (srst_s2)
      first_read <= 1'b1;
    else if (frame_ok)
      first_read <= 1'b0;
  end

  always_comb
  begin
    status_now.irq_source_indicator  = evt_pend;
    status_now.bus_flag              = bus_flag;
    status_now.overvoltage_flag      = sn_s2.overvoltage;
    status_now.undervoltage_flag     = first_read ? sn_s2.battery_fail
                                                  : sn_s2.undervoltage;
    status_now.regulator_hot_warning = sn_s2.regulator_hot;
    status_now.switch_overtemp_flag  = switch_overtemp_flag_flag;
    status_now.wake_input_two        = evt_pend ? wake_src[1]
                                                : sn_s2.wake_input_two;
    status_now.wake_input_one        = evt_pend ? wake_src[0]
                                                : sn_s2.wake_input_one;
  end

  // the snapshot follows live status only while select is high
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      snap <= 8'h00;
    else if (ss_s2)
      snap <= status_now;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      slew_select    <= adsc_pkg::SLEW_RST;
      bus_pullup_off <= 1'b0;
      switch_on      <= adsc_pkg::SWITCH_RST;
      bus_tx_enable  <= 1'b0;
      power_state    <= adsc_pkg::ADSC_RUN;
      wdog_clear     <= 1'b0;
    end
    else
    begin
      slew_select    <= ctrl.slew_select;
      bus_pullup_off <= ctrl.bus_pullup_disconnect
                      & (state != adsc_pkg::ADSC_RUN);
      switch_on      <= (state == adsc_pkg::ADSC_RUN)
                      ? ctrl.switch_enable & {3{~switch_overtemp_flag_flag}}
                      : 3'h0;
      bus_tx_enable  <= (state == adsc_pkg::ADSC_RUN)
                      & ~bus_flag & ~sn_s2.bus_fault;
      power_state    <= state;
      // window timing lives in the watchdog; this only forwards the clear
      wdog_clear     <= frame_ok & ~srst_s2
                      & (ctrl_rx.opsel == adsc_pkg::OPSEL_WDCLR);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_hot_seen;
    sn_s2.switch_overtemp && !srst_s2;
  endsequence

  sequence s_switches_dead;
    switch_overtemp_flag_flag && (ctrl.switch_enable == 3'h0) ##1 (switch_on == 3'h0);
  endsequence

  sequence s_first_lp;
    frame_ok && is_lp && !lp_pend && !srst_s2 && state == adsc_pkg::ADSC_RUN;
  endsequence

  a_commit_good_frame: assert property (
    frame_ok && !srst_s2 && !hs_block |=> ctrl == $past(ctrl_rx))
    else $error("control byte not committed");

  a_drop_bad_frame: assert property (
    frame_end && !frame_ok && !srst_s2 && !hs_block |=> $stable(ctrl))
    else $error("bad frame changed control");

  a_single_lp_held: assert property (
    s_first_lp |=> state == adsc_pkg::ADSC_RUN)
    else $error("single low-power command acted on");

  a_lp_entry_pair: assert property (
    lp_go && !srst_s2 && state == adsc_pkg::ADSC_RUN
    |=> state == ($past(ctrl_rx.opsel[0]) ? adsc_pkg::ADSC_STOP
                                          : adsc_pkg::ADSC_SLEEP))
    else $error("low-power pair not entered");

  a_bus_read_clear: assert property (
    frame_ok && snap[adsc_pkg::ST_BUS_BIT] && !bus_set |=> !bus_flag)
    else $error("bus flag not cleared by read");

  a_switch_hot_off: assert property (
    s_hot_seen |=> s_switches_dead)
    else $error("switches not shut down on overtemp");

  a_first_read_once: assert property (
    frame_ok && !srst_s2
    |=> !first_read ##1 ($past(srst_s2) || !first_read))
    else $error("first-read marker not dropped");

  a_wdog_one_pulse: assert property (
    frame_ok && !srst_s2 && ctrl_rx.opsel == adsc_pkg::OPSEL_WDCLR
    |=> wdog_clear ##1 !wdog_clear)
    else $error("watchdog clear pulse wrong");

  a_stop_wake_run: assert property (
    state == adsc_pkg::ADSC_STOP && any_wake && !srst_s2
    |=> state == adsc_pkg::ADSC_RUN && wake_irq && evt_pend)
    else $error("stop wake not handled");

endmodule

// File: verification/adsc_spi_master.sv
// serial master model standing in for the embedded controller
// assumes: the bench calls xfer one frame at a time; shift clock idles low
`timescale 1ns/10ps
module adsc_spi_master (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // n other than 8 only when a frame is meant to be refused
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    // odd offset keeps the link out of phase with the block clock
    #3.3 ss_n = 1'b0;
    #45;
    for (i = 0; i < n; i++)
    begin
      sck = 1'b1;
      #2 mosi = tx[7];
      tx = {tx[6:0], tx[7]};
      #38 rx = {rx[6:0], miso};
      sck = 1'b0;
      #40;
    end
    ss_n = 1'b1;
    // released data line shows no stale bit
    mosi = ~mosi;
    #150;
  endtask
endmodule

// File: verification/tb_analog_die_spi_control_status.sv
// self-checking bench for the analog-die serial control/status slave
// assumes: adsc_spi_master drives the link; sense levels set by the bench
`timescale 1ns/10ps
module tb_analog_die_spi_control_status;
  logic                  ref_clk;
  logic                  rst;
  logic                  sys_rst_pin;
  logic                  sck;
  logic                  ss_n;
  logic                  mosi;
  logic                  miso;
  logic                  miso_oe_n;
  adsc_pkg::adsc_sense_s sense;
  logic [1:0]            slew_select;
  logic                  bus_pullup_off;
  logic [2:0]            switch_on;
  logic                  bus_tx_enable;
  adsc_pkg::adsc_power_e power_state;
  logic                  wdog_clear;
  logic                  wake_irq;
  logic                  sys_reset_req;
  logic [2:0]            seen;
  logic                  seen_clr;
  logic [7:0]            r;
  int                    mismatches;
  int                    tests_run;
  wire                   miso_pin;

  assign miso_pin = miso_oe_n ? 1'bz : miso;

  adsc_core uut (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .sys_rst_pin     (sys_rst_pin),
    .shift_clock_pin (sck),
    .slave_select_n  (ss_n),
    .mosi            (mosi),
    .miso            (miso),
    .miso_oe_n       (miso_oe_n),
    .sense           (sense),
    .slew_select     (slew_select),
    .bus_pullup_off  (bus_pullup_off),
    .switch_on       (switch_on),
    .bus_tx_enable   (bus_tx_enable),
    .power_state     (power_state),
    .wdog_clear      (wdog_clear),
    .wake_irq        (wake_irq),
    .sys_reset_req   (sys_reset_req)
  );

  adsc_spi_master mst (
    .sck  (sck),
    .ss_n (ss_n),
    .mosi (mosi),
    .miso (miso_pin)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // one-cycle pulses are latched so a task can look at them later
  always @(posedge ref_clk)
    seen <= seen_clr ? 3'h0 : seen | {sys_reset_req, wake_irq, wdog_clear};

  // clearing goes through the latch process so it keeps a single writer
  task automatic clr;
    seen_clr = 1'b1;
    @(posedge ref_clk);
    #1 seen_clr = 1'b0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] outs();
    return {slew_select, bus_pullup_off, switch_on, power_state};
  endfunction

  always @(negedge sck)
    if (!ss_n)
      chk({7'h0, miso_oe_n}, 8'h00);

  task automatic xf(input logic [7:0] tx, input int n);
    mst.xfer(tx, n, r);
    chk({7'h0, miso_oe_n}, 8'h01);
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] tx, input logic [7:0] exp);
    xf(tx, 8);
    chk(r, exp);
  endtask

  task automatic put(input logic [8:0] v);
    sense = v;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset;
    chk(outs(), {2'h0, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
    chk({7'h0, bus_tx_enable}, 8'h01);
  endtask

  // over, battery fail, hot and wake two high
  task automatic t_status;
    put(9'h05A);
    rd(8'h03, 8'h3A);
    rd(8'h03, 8'h2A);
    put(9'h000);
    rd(8'h03, 8'h00);
  endtask

  task automatic t_ctrl;
    int i;
    for (i = 0; i < 4; i++)
    begin
      xf({i[1:0], 1'h0, 3'(i + 1), 2'h3}, 8);
      chk(outs(), {i[1:0], 1'h0, 3'(i + 1), adsc_pkg::ADSC_RUN});
    end
    xf(8'h1F, 7);
    xf(8'h1F, 9);
    chk(outs(), {2'h3, 1'h0, 3'h4, adsc_pkg::ADSC_RUN});
  endtask

  task automatic t_wdog;
    clr;
    xf(8'h03, 8);
    chk({5'h0, seen}, 8'h00);
    xf(8'h02, 8);
    chk({5'h0, seen}, 8'h01);
    chk(outs(), {2'h0, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
  endtask

  task automatic t_fault;
    put(9'h080);
    chk({7'h0, bus_tx_enable}, 8'h00);
    put(9'h000);
    chk({7'h0, bus_tx_enable}, 8'h00);
    rd(8'h03, 8'hC0);
    rd(8'h03, 8'h00);
    chk({7'h0, bus_tx_enable}, 8'h01);
  endtask

  task automatic t_otemp;
    xf(8'h1F, 8);
    chk(outs(), {2'h0, 1'h0, 3'h7, adsc_pkg::ADSC_RUN});
    put(9'h004);
    chk(outs(), {2'h0, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
    put(9'h000);
    chk(outs(), {2'h0, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
    rd(8'h1F, 8'h84);
    rd(8'h1F, 8'h00);
    chk(outs(), {2'h0, 1'h0, 3'h7, adsc_pkg::ADSC_RUN});
  endtask

  // a low-power frame with the other mode does not complete the pair; a matching pair enters
  task automatic t_lowpwr;
    xf(8'hC0, 8);
    xf(8'hE1, 8);
    chk(outs(), {2'h3, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
    xf(8'hE1, 8);
    chk(outs(), {2'h3, 1'h1, 3'h0, adsc_pkg::ADSC_STOP});
    clr;
    put(9'h100);
    put(9'h000);
    chk({5'h0, seen}, 8'h02);
    rd(8'h03, 8'hC0);
    rd(8'h03, 8'h00);
    xf(8'hC0, 8);
    xf(8'hC0, 8);
    chk(outs(), {2'h3, 1'h0, 3'h0, adsc_pkg::ADSC_SLEEP});
    clr;
    // bus wake and wake input one together: cause bits must show input one
    put(9'h101);
    put(9'h000);
    chk({5'h0, seen}, 8'h04);
    rd(8'h03, 8'hC1);
    rd(8'h03, 8'h00);
  endtask

  task automatic t_sysrst;
    xf(8'hA7, 8);
    chk(outs(), {2'h2, 1'h0, 3'h1, adsc_pkg::ADSC_RUN});
    put(9'h010);
    sys_rst_pin = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst_pin = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk(outs(), {2'h0, 1'h0, 3'h0, adsc_pkg::ADSC_RUN});
    rd(8'h03, 8'h10);
    rd(8'h03, 8'h00);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // frames take about a microsecond each; this leaves ample margin
  initial
  begin
    #500000;
    mismatches++;
    conclude;
  end

  initial
  begin
    rst = 1'b1;
    sys_rst_pin = 1'b0;
    sense = 9'h000;
    seen_clr = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    seen_clr = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    t_reset;
    t_status;
    t_ctrl;
    t_wdog;
    t_fault;
    t_otemp;
    t_lowpwr;
    t_sysrst;
    conclude;
  end
endmodule
